// ==== logic/isbsd_defs.vh ====
// register map, field layout, reset values and slice level constants
`ifndef ISBSD_DEFS_VH
`define ISBSD_DEFS_VH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define ISBSD_IDX_FMTSEL 10'h000
`define ISBSD_IDX_SENSE1 10'h05D
`define ISBSD_IDX_SENSE2 10'h05E
`define ISBSD_IDX_STATUS 10'h060
`define ISBSD_IDX_MASK 10'h061
`define ISBSD_IDX_ROUTE 10'h062

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define ISBSD_FMTSEL_MSB 4
`define ISBSD_FMTSEL_RESET 5'h00
`define ISBSD_PWROFF_BIT 6
`define ISBSD_SLICE_MSB 4
`define ISBSD_SLICE_LSB 2
`define ISBSD_PWROFF_RESET 1'h1
`define ISBSD_SLICE_RESET 3'h3
`define ISBSD_MASK_RESET 2'h0

// ---------------------------------------------------------------
// input format codes
// ---------------------------------------------------------------
`define ISBSD_FMT_CVBS_A 5'h00
`define ISBSD_FMT_CVBS_B 5'h01
`define ISBSD_FMT_CVBS_C 5'h02
`define ISBSD_FMT_CVBS_D 5'h03
`define ISBSD_FMT_CVBS_E 5'h06
`define ISBSD_FMT_CVBS_F 5'h07
`define ISBSD_FMT_YC_A 5'h08
`define ISBSD_FMT_YC_B 5'h09
`define ISBSD_FMT_YC_C 5'h0B
`define ISBSD_FMT_COMP 5'h0C
`define ISBSD_FMT_DIFF_A 5'h0E
`define ISBSD_FMT_DIFF_B 5'h0F
`define ISBSD_FMT_DIFF_C 5'h11

// core format one-hot: composite, differential, luma/chroma, component
`define ISBSD_MODE_NONE 4'h0
`define ISBSD_MODE_CVBS 4'h1
`define ISBSD_MODE_DIFF 4'h2
`define ISBSD_MODE_YC 4'h4
`define ISBSD_MODE_COMP 4'h8

// ---------------------------------------------------------------
// slice level in millivolts: base plus step per code
// ---------------------------------------------------------------
`define ISBSD_SLICE_BASE_MV 11'h04B
`define ISBSD_SLICE_STEP_MV 11'h096

`endif

// ==== logic/isbsd_sense_slicer.v ====
// one fault sense pin: input synchroniser and slice level comparator
`timescale 1ns/1ps
`include "isbsd_defs.vh"

module isbsd_sense_slicer (
    input wire clk,
    input wire resetn,
    input wire [10:0] senseMv,
    input wire powerOff,
    input wire [2:0] sliceCode,
    output reg tripped
);

// ---------------------------------------------------------------
// three stage synchroniser with agreement
// ---------------------------------------------------------------
reg [10:0] syncA_reg;
reg [10:0] syncB_reg;
reg [10:0] syncC_reg;
reg [10:0] accepted_reg;
wire [10:0] threshold;

// digitiser word is asynchronous; accept only a settled value
always @(posedge clk) begin
    if (!resetn) begin
        syncA_reg <= 11'h000;
        syncB_reg <= 11'h000;
        syncC_reg <= 11'h000;
        accepted_reg <= 11'h000;
    end else begin
        syncA_reg <= senseMv;
        syncB_reg <= syncA_reg;
        syncC_reg <= syncB_reg;
        if (syncB_reg == syncC_reg) begin
            accepted_reg <= syncC_reg;
        end
    end
end

// slice level: 75 mV plus 150 mV per code step
assign threshold = `ISBSD_SLICE_BASE_MV + ({8'h00, sliceCode} * `ISBSD_SLICE_STEP_MV);

// powered-down slicer never trips; the synchroniser runs on, so a stale word in it can fire right after power-up
always @(posedge clk) begin
    if (!resetn) begin
        tripped <= 1'b0;
    end else begin
        tripped <= !powerOff && (accepted_reg > threshold);
    end
end

endmodule // isbsd_sense_slicer

// ==== logic/isbsd_top.v ====
// input format routing decode and battery short diagnostics with apb registers
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "isbsd_defs.vh"

// Behaviour
// - The input format selection is a five-bit field in bits 4:0 of the register at index 0x00.
// - The selection also tells the video processing core which of the four formats to handle.
// - A predefined scheme connects its inputs by itself and powers down every unused input channel.
// - Composite codes 00000/00001 pick inputs 1/2; further codes pick inputs 3..6 per variant.
// - Luma/chroma codes 01000, 01001 and 01011 route input pairs as the variant allows.
// - Code 01100 selects component on the six-input variant and is reserved on the four-input one.
// - Differential codes 01110, 01111 and 10001 take positive and negative input pairs per variant.
// - Each sense pin compares its divided voltage with its slice level and declares an event above it.
// - An event on either sense pin raises the hardware interrupt on the interrupt request pin.
// - Software can read which of the two sense pins saw the event.
// - After reset the diagnostics are off until software enables them.
// - Bit 6 of indices 0x5D and 0x5E powers each sense pin off, resetting to 1.
// - Bits 4:2 of each sense register set the slice level, 75 mV to 1.125 V in 150 mV steps, reset 011.
module isbsd_top #(
    parameter SIX_INPUTS = 0
) (
    input wire clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire [10:0] firstSenseMv,
    input wire [10:0] secondSenseMv,
    output reg [3:0] coreFormat,
    output reg [5:0] channelPowerOn,
    output reg [2:0] routeFirst,
    output reg [2:0] routeSecond,
    output reg [2:0] routeThird,
    output reg routeValid,
    output wire firstSensePowerOff,
    output wire secondSensePowerOff,
    output wire [2:0] firstSenseThreshold,
    output wire [2:0] secondSenseThreshold,
    output reg irq,
    output wire interruptRequestPinN
);

// ---------------------------------------------------------------
// register state
// ---------------------------------------------------------------
reg [4:0] inputFormatSelect_reg;
reg [1:0] sensePowerOff_reg;
reg [5:0] senseThreshold_reg;
reg [1:0] status_reg;
reg [1:0] status_next;
reg [1:0] mask_reg;
reg [1:0] tripPrev_reg;
wire [1:0] tripped;
wire [21:0] senseMvAll;
wire [1:0] tripEvent;
wire [1:0] statusClear;

// ---------------------------------------------------------------
// apb decode
// ---------------------------------------------------------------
wire [9:0] regIndex;
wire setupPhase;
wire accessPhase;
wire writeEn;
wire readEn;
reg addrHit;

assign regIndex = paddr[11:2];
assign setupPhase = psel && !penable;
assign accessPhase = psel && penable;
assign writeEn = accessPhase && pwrite && addrHit;
assign readEn = accessPhase && !pwrite && addrHit;

// zero wait states keep the bus simple; every access ends in one access cycle
assign pready = 1'b1;
assign pslverr = accessPhase && !addrHit;

// index decode; byte offsets inside a word are ignored
always @* begin
    case (regIndex)
        `ISBSD_IDX_FMTSEL: addrHit = 1'b1;
        `ISBSD_IDX_SENSE1: addrHit = 1'b1;
        `ISBSD_IDX_SENSE2: addrHit = 1'b1;
        `ISBSD_IDX_STATUS: addrHit = 1'b1;
        `ISBSD_IDX_MASK: addrHit = 1'b1;
        `ISBSD_IDX_ROUTE: addrHit = 1'b1;
        default: addrHit = 1'b0;
    endcase
end

// ---------------------------------------------------------------
// writable registers
// ---------------------------------------------------------------
// software-owned fields; diagnostics start powered off
always @(posedge clk) begin
    if (!resetn) begin
        inputFormatSelect_reg <= `ISBSD_FMTSEL_RESET;
        sensePowerOff_reg <= {2{`ISBSD_PWROFF_RESET}};
        senseThreshold_reg <= {2{`ISBSD_SLICE_RESET}};
        mask_reg <= `ISBSD_MASK_RESET;
    end else if (writeEn) begin
        case (regIndex)
            `ISBSD_IDX_FMTSEL: begin
                inputFormatSelect_reg <= pwdata[`ISBSD_FMTSEL_MSB:0];
            end
            `ISBSD_IDX_SENSE1: begin
                sensePowerOff_reg[0] <= pwdata[`ISBSD_PWROFF_BIT];
                senseThreshold_reg[2:0] <= pwdata[`ISBSD_SLICE_MSB:`ISBSD_SLICE_LSB];
            end
            `ISBSD_IDX_SENSE2: begin
                sensePowerOff_reg[1] <= pwdata[`ISBSD_PWROFF_BIT];
                senseThreshold_reg[5:3] <= pwdata[`ISBSD_SLICE_MSB:`ISBSD_SLICE_LSB];
            end
            `ISBSD_IDX_MASK: begin
                mask_reg <= pwdata[1:0];
            end
            default: begin
                mask_reg <= mask_reg;
            end
        endcase
    end
end

assign firstSensePowerOff = sensePowerOff_reg[0];
assign secondSensePowerOff = sensePowerOff_reg[1];
assign firstSenseThreshold = senseThreshold_reg[2:0];
assign secondSenseThreshold = senseThreshold_reg[5:3];

// ---------------------------------------------------------------
// sense pins
// ---------------------------------------------------------------
assign senseMvAll = {secondSenseMv, firstSenseMv};

// one slicer per pin; the slicer only trips while its pin is powered
genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : senseLane
        isbsd_sense_slicer slicer (
            .clk(clk),
            .resetn(resetn),
            .senseMv(senseMvAll[gi*11 +: 11]),
            .powerOff(sensePowerOff_reg[gi]),
            .sliceCode(senseThreshold_reg[gi*3 +: 3]),
            .tripped(tripped[gi])
        );
        // a new crossing of the slice level is one event
        assign tripEvent[gi] = tripped[gi] && !tripPrev_reg[gi];
    end
endgenerate

// edge history for event detection
always @(posedge clk) begin
    if (!resetn) begin
        tripPrev_reg <= 2'h0;
    end else begin
        tripPrev_reg <= tripped;
    end
end

// ---------------------------------------------------------------
// sticky status and interrupt
// ---------------------------------------------------------------
// a read clears only the bits it returned, so an event landing in the setup cycle is not lost
assign statusClear = (readEn && regIndex == `ISBSD_IDX_STATUS) ? prdata[1:0] : 2'h0;

// a new event in the clearing cycle survives: set wins over clear
always @* begin
    status_next = (status_reg & ~statusClear) | tripEvent;
end

always @(posedge clk) begin
    if (!resetn) begin
        status_reg <= 2'h0;
    end else begin
        status_reg <= status_next;
    end
end

// level interrupt while any unmasked event flag stands
always @(posedge clk) begin
    if (!resetn) begin
        irq <= 1'b0;
    end else begin
        irq <= |(status_next & mask_reg);
    end
end

// pin is active low
assign interruptRequestPinN = ~irq;

// ---------------------------------------------------------------
// input routing decode
// ---------------------------------------------------------------
reg [3:0] coreFormat_next;
wire [5:0] channelPowerOn_next;
reg [2:0] routeFirst_next;
reg [2:0] routeSecond_next;
reg [2:0] routeThird_next;
reg routeValid_next;

// reserved codes leave every channel down and report no valid route;
// inputs are numbered 1..6, zero means not connected
always @* begin
    coreFormat_next = `ISBSD_MODE_NONE;
    routeFirst_next = 3'h0;
    routeSecond_next = 3'h0;
    routeThird_next = 3'h0;
    case (inputFormatSelect_reg)
        `ISBSD_FMT_CVBS_A: begin
            coreFormat_next = `ISBSD_MODE_CVBS;
            routeFirst_next = 3'h1;
        end
        `ISBSD_FMT_CVBS_B: begin
            coreFormat_next = `ISBSD_MODE_CVBS;
            routeFirst_next = 3'h2;
        end
        `ISBSD_FMT_CVBS_C: begin
            if (SIX_INPUTS != 0) begin
                coreFormat_next = `ISBSD_MODE_CVBS;
                routeFirst_next = 3'h3;
            end
        end
        `ISBSD_FMT_CVBS_D: begin
            if (SIX_INPUTS != 0) begin
                coreFormat_next = `ISBSD_MODE_CVBS;
                routeFirst_next = 3'h4;
            end
        end
        `ISBSD_FMT_CVBS_E: begin
            coreFormat_next = `ISBSD_MODE_CVBS;
            routeFirst_next = (SIX_INPUTS != 0) ? 3'h5 : 3'h3;
        end
        `ISBSD_FMT_CVBS_F: begin
            coreFormat_next = `ISBSD_MODE_CVBS;
            routeFirst_next = (SIX_INPUTS != 0) ? 3'h6 : 3'h4;
        end
        `ISBSD_FMT_YC_A: begin
            coreFormat_next = `ISBSD_MODE_YC;
            routeFirst_next = 3'h1;
            routeSecond_next = 3'h2;
        end
        `ISBSD_FMT_YC_B: begin
            if (SIX_INPUTS != 0) begin
                coreFormat_next = `ISBSD_MODE_YC;
                routeFirst_next = 3'h3;
                routeSecond_next = 3'h4;
            end
        end
        `ISBSD_FMT_YC_C: begin
            coreFormat_next = `ISBSD_MODE_YC;
            routeFirst_next = (SIX_INPUTS != 0) ? 3'h5 : 3'h3;
            routeSecond_next = (SIX_INPUTS != 0) ? 3'h6 : 3'h4;
        end
        `ISBSD_FMT_COMP: begin
            // four-input variant needs manual muxing, outside this block
            if (SIX_INPUTS != 0) begin
                coreFormat_next = `ISBSD_MODE_COMP;
                routeFirst_next = 3'h1;
                routeSecond_next = 3'h2;
                routeThird_next = 3'h3;
            end
        end
        `ISBSD_FMT_DIFF_A: begin
            coreFormat_next = `ISBSD_MODE_DIFF;
            routeFirst_next = 3'h1;
            routeSecond_next = 3'h2;
        end
        `ISBSD_FMT_DIFF_B: begin
            if (SIX_INPUTS != 0) begin
                coreFormat_next = `ISBSD_MODE_DIFF;
                routeFirst_next = 3'h3;
                routeSecond_next = 3'h4;
            end
        end
        `ISBSD_FMT_DIFF_C: begin
            coreFormat_next = `ISBSD_MODE_DIFF;
            routeFirst_next = (SIX_INPUTS != 0) ? 3'h5 : 3'h3;
            routeSecond_next = (SIX_INPUTS != 0) ? 3'h6 : 3'h4;
        end
        default: begin
            coreFormat_next = `ISBSD_MODE_NONE;
        end
    endcase
    routeValid_next = (coreFormat_next != `ISBSD_MODE_NONE);
end

// power only the channels the chosen scheme uses
genvar ci;
generate
    for (ci = 0; ci < 6; ci = ci + 1) begin : chanPower
        assign channelPowerOn_next[ci] = (routeFirst_next == ci + 1) || (routeSecond_next == ci + 1)
            || (routeThird_next == ci + 1);
    end
endgenerate

// routing outputs come from flops so the analog mux sees clean levels
always @(posedge clk) begin
    if (!resetn) begin
        coreFormat <= `ISBSD_MODE_NONE;
        channelPowerOn <= 6'h00;
        routeFirst <= 3'h0;
        routeSecond <= 3'h0;
        routeThird <= 3'h0;
        routeValid <= 1'b0;
    end else begin
        coreFormat <= coreFormat_next;
        channelPowerOn <= channelPowerOn_next;
        routeFirst <= routeFirst_next;
        routeSecond <= routeSecond_next;
        routeThird <= routeThird_next;
        routeValid <= routeValid_next;
    end
end

// ---------------------------------------------------------------
// read data
// ---------------------------------------------------------------
reg [31:0] readMux;

// unused bits read as zero
always @* begin
    readMux = 32'h00000000;
    case (regIndex)
        `ISBSD_IDX_FMTSEL: readMux[4:0] = inputFormatSelect_reg;
        `ISBSD_IDX_SENSE1: begin
            readMux[`ISBSD_PWROFF_BIT] = sensePowerOff_reg[0];
            readMux[`ISBSD_SLICE_MSB:`ISBSD_SLICE_LSB] = senseThreshold_reg[2:0];
        end
        `ISBSD_IDX_SENSE2: begin
            readMux[`ISBSD_PWROFF_BIT] = sensePowerOff_reg[1];
            readMux[`ISBSD_SLICE_MSB:`ISBSD_SLICE_LSB] = senseThreshold_reg[5:3];
        end
        `ISBSD_IDX_STATUS: begin
            readMux[1:0] = status_reg;
            readMux[5:4] = tripped;
        end
        `ISBSD_IDX_MASK: readMux[1:0] = mask_reg;
        `ISBSD_IDX_ROUTE: begin
            readMux[3:0] = coreFormat;
            readMux[4] = routeValid;
            readMux[13:8] = channelPowerOn;
            readMux[18:16] = routeFirst;
            readMux[22:20] = routeSecond;
            readMux[26:24] = routeThird;
        end
        default: readMux = 32'h00000000;
    endcase
end

// captured in the setup cycle, so it is stable through the access cycle
always @(posedge clk) begin
    if (!resetn) begin
        prdata <= 32'h00000000;
    end else if (setupPhase && !pwrite) begin
        prdata <= readMux;
    end
end

endmodule // isbsd_top

// ==== sim/isbsd_top_chk.sv ====
// concurrent checks on the input routing and fault sense ports
`timescale 1ns/1ps
`include "isbsd_defs.vh"
module isbsd_top_chk (
    input wire clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] coreFormat,
    input wire [5:0] channelPowerOn,
    input wire [2:0] routeFirst,
    input wire [2:0] routeSecond,
    input wire firstSensePowerOff,
    input wire secondSensePowerOff,
    input wire [2:0] firstSenseThreshold,
    input wire [2:0] secondSenseThreshold,
    input wire irq,
    input wire interruptRequestPinN
);
    // ---------------------------------------------------------------
    // decoded bus writes
    // ---------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire accW = psel && penable && pwrite;
    wire fmtW = accW && paddr[11:2] == `ISBSD_IDX_FMTSEL;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    // routing lands two edges after the write: register, then decode
    AST_FMT_CVBS: assert property (fmtW && pwdata[4:0] == 5'h00 |-> ##2
        coreFormat == 4'h1 && routeFirst == 3'h1 && channelPowerOn == 6'h01) else $error("composite code 0 misrouted");
    AST_FMT_YC: assert property (fmtW && pwdata[4:0] == 5'h0B |-> ##2
        coreFormat == 4'h4 && routeFirst == 3'h3 && routeSecond == 3'h4 && channelPowerOn == 6'h0C)
        else $error("luma chroma code misrouted");
    AST_FMT_DIFF: assert property (fmtW && pwdata[4:0] == 5'h0E |-> ##2
        coreFormat == 4'h2 && routeFirst == 3'h1 && routeSecond == 3'h2 && channelPowerOn == 6'h03)
        else $error("differential code misrouted");
    AST_FMT_COMP_RSV: assert property (fmtW && pwdata[4:0] == 5'h0C |-> ##2
        coreFormat == 4'h0 && channelPowerOn == 6'h00) else $error("component code not reserved");
    AST_SENSE1: assert property (accW && paddr[11:2] == `ISBSD_IDX_SENSE1 |=>
        firstSensePowerOff == $past(pwdata[6]) && firstSenseThreshold == $past(pwdata[4:2]))
        else $error("first sense fields not written");
    AST_SENSE2: assert property (accW && paddr[11:2] == `ISBSD_IDX_SENSE2 |=>
        secondSensePowerOff == $past(pwdata[6]) && secondSenseThreshold == $past(pwdata[4:2]))
        else $error("second sense fields not written");
    AST_PIN_INV: assert property (interruptRequestPinN == !irq)
        else $error("interrupt pin not inverse of irq");
    // a rise needs a powered slicer, or a mask write two edges back exposing an old event
    AST_IRQ_POWER: assert property ($rose(irq) |->
        !$past(firstSensePowerOff) || !$past(secondSensePowerOff) || $past(accW, 2))
        else $error("irq with slicers off");
    // a status read drops irq one edge later, a mask write two edges later
    AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(psel && penable) || $past(psel && penable, 2))
        else $error("irq dropped without bus access");
    COV_FMT: cover property (fmtW);
    COV_IRQ_UP: cover property ($rose(irq));
    COV_IRQ_DOWN: cover property ($fell(irq));
endmodule // isbsd_top_chk

bind isbsd_top isbsd_top_chk chk (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .coreFormat,
    .channelPowerOn, .routeFirst, .routeSecond, .firstSensePowerOff, .secondSensePowerOff,
    .firstSenseThreshold, .secondSenseThreshold, .irq, .interruptRequestPinN);

// ==== sim/tb.sv ====
// self-checking bench for input format routing and fault sense diagnostics
`timescale 1ns/1ps
`include "isbsd_defs.vh"
module tb;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [10:0] firstSenseMv = 11'h000;
    reg [10:0] secondSenseMv = 11'h000;
    wire pready;
    wire [31:0] prdata;
    wire pslverr;
    wire irq;
    wire interruptRequestPinN;
    logic [33:0] expQ[$];
    integer miscompares = 0;
    integer tests_run = 0;
    integer i;
    reg [2:0] lvl;
    reg [10:0] thr;

    isbsd_top dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .firstSenseMv(firstSenseMv),
        .secondSenseMv(secondSenseMv), .coreFormat(), .channelPowerOn(), .routeFirst(), .routeSecond(),
        .routeThird(), .routeValid(), .firstSensePowerOff(), .secondSensePowerOff(), .firstSenseThreshold(),
        .secondSenseThreshold(), .irq(irq), .interruptRequestPinN(interruptRequestPinN));

    // 200 MHz clock
    initial forever #2.5 clk = ~clk;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task chk(input logic [33:0] seen, input logic [33:0] want);
        tests_run = tests_run + 1;
        if (seen !== want) begin
            miscompares = miscompares + 1;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task complete_run;
        $display("checks=%0d mismatches=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // one apb transfer; the request holds until pready is seen high
    task apb(input logic wr, input logic [9:0] idx, input logic [31:0] data);
        integer n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 40) begin
            @(posedge clk);
            n = n + 1;
        end
        if (n == 40) begin
            miscompares = miscompares + 1;
            complete_run;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // expected word is {pslverr, irq, prdata} at the access edge
    task rd(input logic [9:0] idx, input logic [33:0] want);
        expQ.push_back(want);
        apb(1'b0, idx, 32'h0);
    endtask

    // route readback word expected for a format code, four-input variant
    function automatic logic [31:0] route(input logic [4:0] c);
        logic [3:0] m;
        logic [5:0] ch;
        logic [2:0] a;
        logic [2:0] b;
        {m, ch, a, b} = 16'h0;
        case (c)
            5'h00: {m, ch, a} = {4'h1, 6'h01, 3'h1};
            5'h01: {m, ch, a} = {4'h1, 6'h02, 3'h2};
            5'h06: {m, ch, a} = {4'h1, 6'h04, 3'h3};
            5'h07: {m, ch, a} = {4'h1, 6'h08, 3'h4};
            5'h08: {m, ch, a, b} = {4'h4, 6'h03, 3'h1, 3'h2};
            5'h0B: {m, ch, a, b} = {4'h4, 6'h0C, 3'h3, 3'h4};
            5'h0E: {m, ch, a, b} = {4'h2, 6'h03, 3'h1, 3'h2};
            5'h11: {m, ch, a, b} = {4'h2, 6'h0C, 3'h3, 3'h4};
            default: m = 4'h0;
        endcase
        return {9'h0, b, 1'b0, a, 2'h0, ch, 3'h0, m != 4'h0, m};
    endfunction

    // read monitor: oldest note against what the bus returns
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expQ.size() == 0) chk(34'h0, 34'h3FFFFFFFF);
            else chk({pslverr, irq, prdata}, expQ.pop_front());
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        i = $urandom(32'hCB93C7FA);
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(`ISBSD_IDX_ROUTE, {2'h0, route(5'h00)});
        rd(`ISBSD_IDX_SENSE1, 34'h4C);
        rd(`ISBSD_IDX_SENSE2, 34'h4C);
        rd(`ISBSD_IDX_MASK, 34'h0);
        rd(10'h3FF, 34'h200000000);
        // every programmable code, random junk in the unused bits
        for (i = 0; i < 18; i = i + 1) begin
            if (i == 4 || i == 5 || i == 10 || i == 13 || i == 16) continue;
            apb(1'b1, `ISBSD_IDX_FMTSEL, ($urandom & 32'hFFFFFFE0) | i);
            rd(`ISBSD_IDX_FMTSEL, {29'h0, i[4:0]});
            rd(`ISBSD_IDX_ROUTE, {2'h0, route(i[4:0])});
        end
        // powered-off slicers ignore even full scale
        lvl = $urandom_range(7, 0);
        thr = `ISBSD_SLICE_BASE_MV + `ISBSD_SLICE_STEP_MV * lvl;
        apb(1'b1, `ISBSD_IDX_MASK, 32'h3);
        firstSenseMv <= 11'h7FF;
        secondSenseMv <= 11'h7FF;
        repeat (10) @(posedge clk);
        // new levels settle before power-up, else the stale full-scale word trips for a cycle
        firstSenseMv <= thr;
        secondSenseMv <= 11'h465;
        rd(`ISBSD_IDX_STATUS, 34'h0);
        apb(1'b1, `ISBSD_IDX_SENSE1, {27'h0, lvl, 2'h0});
        repeat (10) @(posedge clk);
        rd(`ISBSD_IDX_STATUS, 34'h0);
        firstSenseMv <= thr + 11'h001;
        repeat (10) @(posedge clk);
        rd(`ISBSD_IDX_STATUS, 34'h100000011);
        rd(`ISBSD_IDX_STATUS, 34'h10);
        // second pin masked, then exposed by the mask
        apb(1'b1, `ISBSD_IDX_MASK, 32'h1);
        apb(1'b1, `ISBSD_IDX_SENSE2, 32'h1C);
        repeat (10) @(posedge clk);
        rd(`ISBSD_IDX_STATUS, 34'h10);
        secondSenseMv <= 11'h466;
        repeat (10) @(posedge clk);
        chk({33'h0, interruptRequestPinN}, 34'h1);
        apb(1'b1, `ISBSD_IDX_MASK, 32'h3);
        repeat (2) @(posedge clk);
        chk({33'h0, interruptRequestPinN}, 34'h0);
        rd(`ISBSD_IDX_STATUS, 34'h100000032);
        rd(`ISBSD_IDX_STATUS, 34'h30);
        firstSenseMv <= 11'h000;
        secondSenseMv <= 11'h000;
        repeat (10) @(posedge clk);
        rd(`ISBSD_IDX_STATUS, 34'h0);
        repeat (4) @(posedge clk);
        complete_run;
    end
endmodule // tb
